// ### hw/fnbcfg_top.sv
// Purpose: decode and validate station number and bit rate of a fieldbus node
// Assumes: APB slave on SYS_CLK, SRST synchronous active high, switches asynchronous
// Notes:   one source selected at a time; decoded result registered every clock
`timescale 1ns/1ps
`include "fnbcfg_consts.svh"

module fnbcfg_top (
  input  wire logic                 SYS_CLK,       // 10 MHz system clock
  input  wire logic                 SRST,          // synchronous reset, active high
  input  wire logic                 PSEL,          // apb select
  input  wire logic                 PENABLE,       // apb access phase
  input  wire logic                 PWRITE,        // apb write
  input  wire logic [7:0]           PADDR,         // apb byte address
  input  wire logic [31:0]          PWDATA,        // apb write data
  output logic      [31:0]          PRDATA,        // apb read data
  output logic                      PREADY,        // apb ready
  output logic                      PSLVERR,       // apb error on unmapped address
  input  wire logic [9:0]           SWITCH_FIELD,  // dip switches, bit 9 = rate sw 1
  input  wire logic                 DUP_SEEN,      // engine saw our station in use
  output fnbcfg_pkg::fnbcfg_cfg_s   CFG,           // decoded configuration
  output logic                      COMM_ENABLE,   // node may take part on the bus
  output logic                      CMD_FROM_BUS   // drive commands come over the bus
);

  // switch synchroniser: stage one feeds only stage two
  logic [9:0] sw_meta_reg;
  logic [9:0] sw_sync_reg;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      sw_meta_reg <= 10'h000;
      sw_sync_reg <= 10'h000;
    end else begin
      sw_meta_reg <= SWITCH_FIELD;
      sw_sync_reg <= sw_meta_reg;
    end
  end

  // rate switch 1 is the code msb, address switch 1 is station bit 6
  logic [2:0] rate_switch_bits;
  logic [6:0] switch_station;

  assign rate_switch_bits = sw_sync_reg[9:7];
  assign switch_station   = sw_sync_reg[6:0];

  // software-visible state
  fnbcfg_pkg::fnbcfg_src_e src_reg;
  logic        no800_reg;
  logic [15:0] drv_rate_reg;
  logic [6:0]  drv_station_reg;
  logic [6:0]  srv_station_reg;
  logic [2:0]  srv_rate_reg;
  logic [6:0]  plc_station_pend_reg;
  logic [2:0]  plc_rate_pend_reg;
  logic [6:0]  plc_station_reg;
  logic [2:0]  plc_rate_reg;
  logic [3:0]  cmd_src_reg;
  logic        dup_off_reg;

  logic acc;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic ctrl_wr;

  // write lands at the end of the first access cycle, on the same edge that raises ready; no abort possible
  assign acc     = PSEL & PENABLE & ~PREADY;
  assign wr_en   = acc & PWRITE & mapped;
  assign rd_en   = acc & ~PWRITE;
  assign ctrl_wr = wr_en && PADDR == `FNBCFG_OFF_CTRL;

  always_comb begin
    case (PADDR)
      `FNBCFG_OFF_CTRL,
      `FNBCFG_OFF_DRV_RATE,
      `FNBCFG_OFF_DRV_STATION,
      `FNBCFG_OFF_SRV_STATION,
      `FNBCFG_OFF_SRV_RATE,
      `FNBCFG_OFF_PLC_STATION,
      `FNBCFG_OFF_PLC_RATE,
      `FNBCFG_OFF_APPLY,
      `FNBCFG_OFF_STATUS,
      `FNBCFG_OFF_CMD_SRC: mapped = 1'b1;
      default:             mapped = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      src_reg   <= fnbcfg_pkg::fnbcfg_src_e'(`FNBCFG_RST_CTRL);
      no800_reg <= 1'b0;
    end else if (ctrl_wr) begin
      src_reg   <= fnbcfg_pkg::fnbcfg_src_e'(PWDATA[`FNBCFG_CTRL_SRC_MSB:`FNBCFG_CTRL_SRC_LSB]);
      no800_reg <= PWDATA[`FNBCFG_CTRL_NO800_BIT];
    end
  end

  // drive and servo parameters act on the next decode, no restart needed
  // wr_en already excludes unmapped offsets, so a stray write never lands
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      drv_rate_reg    <= `FNBCFG_RST_DRV_RATE;
      drv_station_reg <= `FNBCFG_RST_STATION;
      srv_station_reg <= `FNBCFG_RST_STATION;
      srv_rate_reg    <= `FNBCFG_RST_SRV_RATE;
      cmd_src_reg     <= `FNBCFG_RST_CMD_SRC;
    end else if (wr_en) begin
      case (PADDR)
        `FNBCFG_OFF_DRV_RATE:    drv_rate_reg    <= PWDATA[15:0];
        `FNBCFG_OFF_DRV_STATION: drv_station_reg <= PWDATA[6:0];
        `FNBCFG_OFF_SRV_STATION: srv_station_reg <= PWDATA[6:0];
        `FNBCFG_OFF_SRV_RATE:    srv_rate_reg    <= PWDATA[2:0];
        `FNBCFG_OFF_CMD_SRC:     cmd_src_reg     <= PWDATA[3:0];
        default: begin
        end
      endcase
    end
  end

  // controller values wait in a pending copy until restart or apply
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      plc_station_pend_reg <= `FNBCFG_RST_STATION;
      plc_rate_pend_reg    <= `FNBCFG_RST_PLC_RATE;
    end else if (wr_en && PADDR == `FNBCFG_OFF_PLC_STATION) begin
      plc_station_pend_reg <= PWDATA[6:0];
    end else if (wr_en && PADDR == `FNBCFG_OFF_PLC_RATE) begin
      plc_rate_pend_reg    <= PWDATA[2:0];
    end
  end

  // a reset counts as a restart, so the pending copy is loaded one cycle later
  logic boot_reg;
  logic plc_apply;

  // apply strobe stands in for downloading the running program again
  assign plc_apply = wr_en && PADDR == `FNBCFG_OFF_APPLY && PWDATA[`FNBCFG_APPLY_BIT];

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      boot_reg        <= 1'b1;
      plc_station_reg <= `FNBCFG_RST_STATION;
      plc_rate_reg    <= `FNBCFG_RST_PLC_RATE;
    end else begin
      boot_reg <= 1'b0;
      if (boot_reg || plc_apply) begin
        plc_station_reg <= plc_station_pend_reg;
        plc_rate_reg    <= plc_rate_pend_reg;
      end
    end
  end

  // duplicate shutdown is sticky; a new report beats a clear in the same cycle
  logic dup_clr;

  assign dup_clr = wr_en && PADDR == `FNBCFG_OFF_STATUS && PWDATA[`FNBCFG_ST_DUPOFF_BIT];

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      dup_off_reg <= 1'b0;
    end else if (DUP_SEEN) begin
      dup_off_reg <= 1'b1;
    end else if (dup_clr) begin
      dup_off_reg <= 1'b0;
    end
  end

  // thousands digit by compares against each step; a 16-bit divider costs far more
  logic [9:1]  drv_step;
  logic [15:0] drv_digit;

  for (genvar k = 1; k <= 9; k++) begin : g_drv_step
    assign drv_step[k] = drv_rate_reg >= 16'(k * `FNBCFG_DRV_DIGIT_DIV);
  end

  // ten thousand and more still counts as digit 9, so it stays refused
  always_comb begin
    drv_digit = 16'h0000;
    for (int j = 1; j <= 9; j++) begin
      if (drv_step[j]) begin
        drv_digit = 16'(j);
      end
    end
  end

  // digits 0..5 keep their code, 6 means 1000 kbit/s, 7..9 are refused
  logic [2:0] drv_rate_code;
  logic       drv_rate_ok;

  always_comb begin
    drv_rate_code = drv_digit[2:0];
    drv_rate_ok   = drv_digit <= `FNBCFG_DRV_DIGIT_MAX;
    if (drv_digit == `FNBCFG_DRV_DIGIT_MAX) begin
      drv_rate_code = `FNBCFG_RATE_CODE_1000;
    end
  end

  // a servo without 800 kbit/s falls back to 1000 kbit/s on code 6
  logic [2:0] srv_rate_code;

  always_comb begin
    srv_rate_code = srv_rate_reg;
    if (no800_reg && srv_rate_reg == `FNBCFG_RATE_CODE_800) begin
      srv_rate_code = `FNBCFG_RATE_CODE_1000;
    end
  end

  // decode of the selected source
  logic [6:0]  sel_station;
  logic [2:0]  sel_rate;
  logic        sel_rate_ok;

  always_comb begin
    sel_station = `FNBCFG_RST_STATION;
    sel_rate    = 3'h0;
    sel_rate_ok = 1'b0;
    case (src_reg)
      fnbcfg_pkg::FNBCFG_SRC_SWITCH: begin
        sel_station = switch_station;
        sel_rate    = rate_switch_bits;
        sel_rate_ok = 1'b1;
      end
      fnbcfg_pkg::FNBCFG_SRC_DRIVE: begin
        sel_station = drv_station_reg;
        sel_rate    = drv_rate_code;
        sel_rate_ok = drv_rate_ok;
      end
      fnbcfg_pkg::FNBCFG_SRC_SERVO: begin
        sel_station = srv_station_reg;
        sel_rate    = srv_rate_code;
        sel_rate_ok = 1'b1;
      end
      fnbcfg_pkg::FNBCFG_SRC_PLC: begin
        sel_station = plc_station_reg;
        sel_rate    = plc_rate_reg;
        sel_rate_ok = 1'b1;
      end
      default: begin
        sel_rate_ok = 1'b0;
      end
    endcase
  end

  logic sel_addr_ok;

  // 0 and 64..127 both fall outside 1..63
  assign sel_addr_ok = sel_station >= `FNBCFG_STATION_MIN &&
                       sel_station <= `FNBCFG_STATION_MAX;

  // registered result; valid low from reset until a legal decode
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      CFG <= '0;
    end else begin
      CFG.valid         <= sel_addr_ok & sel_rate_ok;
      CFG.reserved_addr <= ~sel_addr_ok;
      CFG.bad_rate      <= ~sel_rate_ok;
      CFG.station       <= sel_station;
      CFG.rate          <= fnbcfg_pkg::fnbcfg_rate_e'(sel_rate);
    end
  end

  // one rate for the whole network is the integrator's job; we only report ours
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      COMM_ENABLE  <= 1'b0;
      CMD_FROM_BUS <= 1'b0;
    end else begin
      COMM_ENABLE  <= sel_addr_ok & sel_rate_ok & ~dup_off_reg & ~DUP_SEEN;
      CMD_FROM_BUS <= cmd_src_reg == `FNBCFG_CMD_SRC_COMM;
    end
  end

  // read mux
  // apply and unmapped offsets read zero
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      `FNBCFG_OFF_CTRL: begin
        rd_mux[`FNBCFG_CTRL_SRC_MSB:`FNBCFG_CTRL_SRC_LSB] = src_reg;
        rd_mux[`FNBCFG_CTRL_NO800_BIT] = no800_reg;
      end
      `FNBCFG_OFF_DRV_RATE:    rd_mux[15:0] = drv_rate_reg;
      `FNBCFG_OFF_DRV_STATION: rd_mux[6:0]  = drv_station_reg;
      `FNBCFG_OFF_SRV_STATION: rd_mux[6:0]  = srv_station_reg;
      `FNBCFG_OFF_SRV_RATE:    rd_mux[2:0]  = srv_rate_reg;
      `FNBCFG_OFF_PLC_STATION: rd_mux[6:0]  = plc_station_pend_reg;
      `FNBCFG_OFF_PLC_RATE:    rd_mux[2:0]  = plc_rate_pend_reg;
      `FNBCFG_OFF_CMD_SRC:     rd_mux[3:0]  = cmd_src_reg;
      `FNBCFG_OFF_STATUS: begin
        rd_mux[`FNBCFG_ST_VALID_BIT]    = CFG.valid;
        rd_mux[`FNBCFG_ST_RESERVED_BIT] = CFG.reserved_addr;
        rd_mux[`FNBCFG_ST_BADRATE_BIT]  = CFG.bad_rate;
        rd_mux[`FNBCFG_ST_DUPOFF_BIT]   = dup_off_reg;
        rd_mux[`FNBCFG_ST_COMM_BIT]     = COMM_ENABLE;
        rd_mux[`FNBCFG_ST_RATE_LSB +: 3]    = CFG.rate;
        rd_mux[`FNBCFG_ST_STATION_LSB +: 7] = CFG.station;
      end
      default: begin
      end
    endcase
  end

  // one wait state: ready rises in the second access cycle
  // error stands for the ready cycle only; read data holds until the next access
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= acc;
      PSLVERR <= acc & ~mapped;
      if (rd_en && mapped) begin
        PRDATA <= rd_mux;
      end else if (acc) begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

endmodule

// ### hw/fnbcfg_consts.svh
// Purpose: offsets, field positions, reset values and codes of the node config decoder
// Assumes: included by bare name, definitions only
// Notes:   all register offsets are byte addresses of aligned 32-bit words
`ifndef FNBCFG_CONSTS_SVH
`define FNBCFG_CONSTS_SVH

`define FNBCFG_OFF_CTRL          8'h00
`define FNBCFG_OFF_DRV_RATE      8'h04
`define FNBCFG_OFF_DRV_STATION   8'h08
`define FNBCFG_OFF_SRV_STATION   8'h0C
`define FNBCFG_OFF_SRV_RATE      8'h10
`define FNBCFG_OFF_PLC_STATION   8'h14
`define FNBCFG_OFF_PLC_RATE      8'h18
`define FNBCFG_OFF_APPLY         8'h1C
`define FNBCFG_OFF_STATUS        8'h20
`define FNBCFG_OFF_CMD_SRC       8'h24

`define FNBCFG_RST_CTRL          2'h0
`define FNBCFG_RST_DRV_RATE      16'h138D
`define FNBCFG_RST_SRV_RATE      3'h5
`define FNBCFG_RST_STATION       7'h00
`define FNBCFG_RST_PLC_RATE      3'h5
`define FNBCFG_RST_CMD_SRC       4'h0

`define FNBCFG_CTRL_SRC_LSB      0
`define FNBCFG_CTRL_SRC_MSB      1
`define FNBCFG_CTRL_NO800_BIT    2
`define FNBCFG_APPLY_BIT         0
`define FNBCFG_ST_VALID_BIT      0
`define FNBCFG_ST_RESERVED_BIT   1
`define FNBCFG_ST_BADRATE_BIT    2
`define FNBCFG_ST_DUPOFF_BIT     3
`define FNBCFG_ST_COMM_BIT       4
`define FNBCFG_ST_RATE_LSB       8
`define FNBCFG_ST_STATION_LSB    16

`define FNBCFG_STATION_MIN       7'h01
`define FNBCFG_STATION_MAX       7'h3F
`define FNBCFG_DRV_DIGIT_DIV     16'h03E8
`define FNBCFG_DRV_DIGIT_MAX     16'h0006
`define FNBCFG_CMD_SRC_COMM      4'h2
`define FNBCFG_RATE_CODE_800     3'h6
`define FNBCFG_RATE_CODE_1000    3'h7

`endif

// ### hw/fnbcfg_pkg.sv
// Purpose: types shared by the node config decoder
// Assumes: constants live in fnbcfg_consts.svh
// Notes:   rate code 0..7 = 20, 50, 100, 125, 250, 500, 800, 1000 kbit/s
package fnbcfg_pkg;

  typedef enum logic [1:0] {
    FNBCFG_SRC_SWITCH,
    FNBCFG_SRC_DRIVE,
    FNBCFG_SRC_SERVO,
    FNBCFG_SRC_PLC
  } fnbcfg_src_e;

  typedef enum logic [2:0] {
    FNBCFG_R20K,
    FNBCFG_R50K,
    FNBCFG_R100K,
    FNBCFG_R125K,
    FNBCFG_R250K,
    FNBCFG_R500K,
    FNBCFG_R800K,
    FNBCFG_R1000K
  } fnbcfg_rate_e;

  typedef struct packed {
    logic         valid;
    logic         reserved_addr;
    logic         bad_rate;
    logic [6:0]   station;
    fnbcfg_rate_e rate;
  } fnbcfg_cfg_s;

endpackage

// ### tb/fnbcfg_sva.sv
// Purpose: port checks for the node config decoder
// Assumes: sees only top ports, one clock, SRST synchronous
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`include "fnbcfg_consts.svh"
module fnbcfg_sva (
  input wire logic                    SYS_CLK,      // clock
  input wire logic                    SRST,         // reset
  input wire logic                    PSEL,         // select
  input wire logic                    PENABLE,      // access
  input wire logic                    PWRITE,       // write
  input wire logic [7:0]              PADDR,        // address
  input wire logic [31:0]             PWDATA,       // wdata
  input wire logic [31:0]             PRDATA,       // rdata
  input wire logic                    PREADY,       // ready
  input wire logic                    PSLVERR,      // error
  input wire logic                    DUP_SEEN,     // duplicate
  input wire fnbcfg_pkg::fnbcfg_cfg_s CFG,          // decode
  input wire logic                    COMM_ENABLE,  // bus on
  input wire logic                    CMD_FROM_BUS  // bus commands
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  sequence s_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_cmd_wr;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == `FNBCFG_OFF_CMD_SRC && !PSLVERR;
  endsequence
  chk_apb_wait: assert property (s_access |=> PREADY)
    else $error("no ready after access");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  chk_err_rdata: assert property (PSLVERR |-> PREADY && PRDATA == 32'h00000000)
    else $error("error without ready or with data");
  chk_reset_clear: assert property (
    disable iff (1'h0) SRST |=> !CFG.valid && !COMM_ENABLE && !CMD_FROM_BUS)
    else $error("outputs not cleared by reset");
  chk_valid_range: assert property (CFG.valid |-> CFG.station != 7'h00 && !CFG.station[6])
    else $error("valid with station outside 1..63");
  chk_valid_flags: assert property (CFG.valid |-> !CFG.reserved_addr && !CFG.bad_rate)
    else $error("valid with reserved or bad rate");
  chk_dup_off: assert property (DUP_SEEN |=> !COMM_ENABLE)
    else $error("still on bus after duplicate");
  chk_comm_legal: assert property (COMM_ENABLE |-> CFG.valid)
    else $error("on bus without legal config");
  chk_cmd_src: assert property (
    s_cmd_wr |=> CMD_FROM_BUS == (($past(PWDATA) & 32'h0000000F) == 32'h00000002))
    else $error("command source decode wrong");
endmodule

// ### tb/fnbcfg_peer_model.sv
// Purpose: stand-in for a station already present on the shared bus
// Assumes: CAN engine reports our number in use one clock later
// Notes:   holds one fixed station number only
`timescale 1ns/1ps
module fnbcfg_peer_model #(
  parameter logic [6:0] PEER_STATION = 7'h2A  // number owned by the peer
) (
  input wire logic       clk,      // system clock
  input wire logic       srst,     // sync reset
  input wire logic [6:0] station,  // our decoded station
  input wire logic       valid,    // our config legal
  output logic           dup_seen  // peer owns our number
);
  // peer joined first, so the later node must back off
  always_ff @(posedge clk) begin
    if (srst) begin
      dup_seen <= 1'h0;
    end else begin
      dup_seen <= valid && station == PEER_STATION;
    end
  end
endmodule

// ### tb/fieldbus_node_config_decoder_tb.sv
// Purpose: self-checking bench of the node config decoder
// Assumes: APB master at rising edge, peer model drives duplicate line
// Notes:   random values from a fixed lfsr seed
`timescale 1ns/1ps
`include "fnbcfg_consts.svh"
module fieldbus_node_config_decoder_tb;
  logic                    sys_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic                    dup_seen, comm_enable, cmd_from_bus, err;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, rd, seed;
  logic [9:0]              switch_field, sw;
  logic [6:0]              st;
  logic [6:0]              corner [8] = '{7'h00, 7'h01, 7'h3F, 7'h40, 7'h7F, 7'h20, 7'h11, 7'h3E};
  fnbcfg_pkg::fnbcfg_cfg_s cfg;
  int                      bad_count, checks_done;

  fnbcfg_top u_dut (.SYS_CLK(sys_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SWITCH_FIELD(switch_field), .DUP_SEEN(dup_seen), .CFG(cfg),
    .COMM_ENABLE(comm_enable), .CMD_FROM_BUS(cmd_from_bus));
  fnbcfg_peer_model u_peer (.clk(sys_clk), .srst(srst), .station(cfg.station),
    .valid(cfg.valid), .dup_seen(dup_seen));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_cfg(input logic [6:0] s, input logic [2:0] r);
    return {21'h0, s != 7'h00 && !s[6], s, r};
  endfunction
  function automatic logic [31:0] seen();
    return {21'h0, cfg.valid, cfg.station, cfg.rate};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  // far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    complete_run();
  end
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata, switch_field} = {4'h8, 8'h0, 32'h0, 10'h0};
    bad_count = 0;
    checks_done = 0;
    seed = 32'h00017130;
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    settle(0);
    check(32'({cfg.valid, comm_enable, cmd_from_bus}), 32'h0);
    rdchk(`FNBCFG_OFF_DRV_RATE, 32'h0000138D);
    rdchk(`FNBCFG_OFF_SRV_RATE, 32'h00000005);
    rdchk(8'h28, 32'h0);
    check(32'(err), 32'h1);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      sw = (i < 8) ? {i[2:0], corner[i]} : seed[9:0];
      @(posedge sys_clk);
      switch_field <= sw;
      settle(4);
      check(seen(), exp_cfg(sw[6:0], sw[9:7]));
      check(32'(cfg.reserved_addr), 32'(sw[6:0] == 7'h00 || sw[6]));
    end
    $display("switch test done");
    wr(`FNBCFG_OFF_CTRL, 32'h1);
    for (int d = 0; d < 10; d++) begin
      seed = lfsr(seed);
      st = (d == 2) ? 7'h00 : (d == 3) ? 7'h40 : {1'h0, seed[5:0] | 6'h01};
      wr(`FNBCFG_OFF_DRV_STATION, 32'(st));
      wr(`FNBCFG_OFF_DRV_RATE, 32'(d * 1000 + seed[25:16] % 1000));
      settle(1);
      if (d > 6) check(32'({cfg.valid, cfg.bad_rate}), 32'h1);
      else check(seen(), exp_cfg(st, d == 6 ? 3'h7 : 3'(d)));
    end
    $display("drive test done");
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      st = (k == 1) ? 7'h7F : {1'h0, seed[5:0] | 6'h01};
      wr(`FNBCFG_OFF_CTRL, k < 8 ? 32'h2 : 32'h6);
      wr(`FNBCFG_OFF_SRV_STATION, 32'(st));
      wr(`FNBCFG_OFF_SRV_RATE, 32'(k[2:0]));
      settle(1);
      check(seen(), exp_cfg(st, k == 14 ? 3'h7 : k[2:0]));
    end
    $display("servo test done");
    wr(`FNBCFG_OFF_CTRL, 32'h3);
    wr(`FNBCFG_OFF_PLC_STATION, 32'h9);
    wr(`FNBCFG_OFF_PLC_RATE, 32'h3);
    settle(1);
    check(seen(), exp_cfg(7'h00, 3'h5));
    wr(`FNBCFG_OFF_APPLY, 32'h1);
    settle(1);
    check(seen(), exp_cfg(7'h09, 3'h3));
    $display("controller test done");
    wr(`FNBCFG_OFF_CTRL, 32'h1);
    wr(`FNBCFG_OFF_DRV_RATE, 32'h0000138D);
    wr(`FNBCFG_OFF_DRV_STATION, 32'h2A);
    settle(3);
    check(32'({comm_enable, cfg.valid}), 32'h1);
    rdchk(`FNBCFG_OFF_STATUS, 32'h002A0509);
    wr(`FNBCFG_OFF_DRV_STATION, 32'h2B);
    wr(`FNBCFG_OFF_STATUS, 32'h8);
    settle(1);
    check(32'(comm_enable), 32'h1);
    $display("duplicate test done");
    wr(`FNBCFG_OFF_CMD_SRC, 32'h2);
    settle(1);
    check(32'(cmd_from_bus), 32'h1);
    wr(`FNBCFG_OFF_CMD_SRC, 32'h3);
    settle(1);
    check(32'(cmd_from_bus), 32'h0);
    $display("command source test done");
    complete_run();
  end
endmodule

bind fnbcfg_top fnbcfg_sva u_sva (.SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .DUP_SEEN(DUP_SEEN), .CFG(CFG),
  .COMM_ENABLE(COMM_ENABLE), .CMD_FROM_BUS(CMD_FROM_BUS));
